//--- hw/gst_timer.sv
// Gated sixteen-bit timer with prescaler, clock source select and APB registers
//
// Behaviour
// - Sixteen-bit up-counter in two byte registers; byte writes replace that part at once.
// - Off when timer_on is 0; with gate_enable set counts only while gate allows.
// - Source 11 low-freq osc, 10 pin or crystal, 01 system, 00 instruction clock.
// - System clock source gives four counts per instruction cycle.
// - External source counts rising edges, synchronised or asynchronous.
// - Counter mode needs a falling edge before the first counted rising edge.
// - Prescaler divides the selected clock by 1, 2, 4 or 8.
// - Prescaler hidden from software; any count byte write clears it.
// - crystal_osc_enable starts the crystal oscillator; it keeps running in sleep.
// - no_sync bypasses the synchroniser; external counting continues in sleep and wakes.
// - Switching sync mode may lose or add one increment.
// - Byte reads stay valid while counting; software handles overflow between reads.
// - Gated operation counts while the gate is active and holds otherwise.
// - gate_polarity 0 counts while gate low, 1 while gate high.
// - Gate source 00 pin, 01 companion overflow, 10 comparator one, 11 two.
// - Companion timer wrap gives a high pulse on the gate input.
// - Comparator gate sources are optionally synchronised to the counter clock.
// - Toggle mode routes the gate through a flip-flop toggling on each rising edge.
// - With toggle mode clear the toggle flip-flop is held at zero.
// - Rollover FFFFh to 0000h sets the overflow flag; only software clears it.
// - Clearing timer_on stops counting and clears the gate flip-flop.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "gst_defs.svh"

module gst_timer
  import gst_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire gst_apb_req_t apb_req_i,
  output logic [31:0]       prdata_o,
  output logic              pready_o,
  output logic              pslverr_o,
  input  wire logic         external_clock_pin_i,
  input  wire logic         crystal_in_i,
  output logic              crystal_out_o,
  input  wire logic         low_freq_internal_osc_i,
  input  wire logic         gate_pin_i,
  input  wire logic         companion_8bit_timer_ovf_i,
  input  wire logic         comparator_one_out_i,
  input  wire logic         comparator_two_out_i,
  input  wire logic         sleep_i,
  output logic [15:0]       count_o,
  output logic              overflow_flag_o,
  output logic              wake_o
);

  // ==========================================================================
  // Helper functions
  function automatic logic rise(input logic prev, input logic cur);
    rise = ~prev & cur;
  endfunction

  function automatic logic fall(input logic prev, input logic cur);
    fall = prev & ~cur;
  endfunction

  // Prescaler output: low bits of the prescale counter all ones
  function automatic logic prescale_hit(input logic [2:0] cnt, input logic [1:0] sel);
    logic [2:0] mask;
    mask = 3'h0;
    case (sel)
      2'h0:    mask = 3'h0;
      2'h1:    mask = 3'h1;
      2'h2:    mask = 3'h3;
      default: mask = 3'h7;
    endcase
    prescale_hit = ((cnt & mask) == mask);
  endfunction

  // ==========================================================================
  // State and decode signals
  gst_state_t  q;
  gst_state_t  next_q;
  logic        setup_ph;
  logic        access_ph;
  logic        wr_ctrl;
  logic        wr_gate;
  logic        wr_low;
  logic        wr_high;
  logic        wr_stat;
  logic        wr_count;
  logic        mapped;
  logic        ext_pin_sel;
  logic        ext_lvl;
  logic        src_tick;
  logic        awake;
  logic        gate_raw;
  logic        gate_lvl;
  logic        gate_val;
  logic        run;
  logic        pre_tick;
  logic        cnt_tick;
  logic        ovf_set;
  logic [31:0] rd_mux;

  // Bus phase and address decode
  always_comb begin
    setup_ph  = apb_req_i.psel & ~apb_req_i.penable;
    access_ph = apb_req_i.psel & apb_req_i.penable;
    mapped    = (apb_req_i.paddr == `GST_OFF_CTRL) || (apb_req_i.paddr == `GST_OFF_GATE) ||
                (apb_req_i.paddr == `GST_OFF_CNT_LOW) ||
                (apb_req_i.paddr == `GST_OFF_CNT_HIGH) ||
                (apb_req_i.paddr == `GST_OFF_STATUS);
    wr_ctrl   = access_ph & apb_req_i.pwrite & (apb_req_i.paddr == `GST_OFF_CTRL);
    wr_gate   = access_ph & apb_req_i.pwrite & (apb_req_i.paddr == `GST_OFF_GATE);
    wr_low    = access_ph & apb_req_i.pwrite & (apb_req_i.paddr == `GST_OFF_CNT_LOW);
    wr_high   = access_ph & apb_req_i.pwrite & (apb_req_i.paddr == `GST_OFF_CNT_HIGH);
    wr_stat   = access_ph & apb_req_i.pwrite & (apb_req_i.paddr == `GST_OFF_STATUS);
    wr_count  = wr_low | wr_high;
  end

  // Read data mux, sampled in the setup phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (apb_req_i.paddr)
      `GST_OFF_CTRL:     rd_mux = {24'h00_0000, q.ctrl};
      `GST_OFF_GATE:     rd_mux = {24'h00_0000, q.gate};
      `GST_OFF_CNT_LOW:  rd_mux = {24'h00_0000, q.count[7:0]};
      `GST_OFF_CNT_HIGH: rd_mux = {24'h00_0000, q.count[15:8]};
      `GST_OFF_STATUS: begin
        rd_mux[`GST_STAT_OVF_BIT]   = q.overflow_flag;
        rd_mux[`GST_STAT_ARMED_BIT] = q.armed;
      end
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // Clock source levels, edges and tick selection
  always_comb begin
    ext_pin_sel = q.ctrl.crystal_osc_enable ? crystal_in_i : external_clock_pin_i;
    ext_lvl     = q.ctrl.no_sync ? q.ext_raw : q.ext_s2;
    case (q.ctrl.clock_source_select)
      GST_SRC_INSTR: src_tick = (q.idiv == `GST_INSTR_LAST);
      GST_SRC_SYS:   src_tick = 1'b1;
      GST_SRC_EXT:   src_tick = rise(q.ext_prev, ext_lvl) & q.armed;
      GST_SRC_LFOSC: src_tick = rise(q.lf_prev, q.lf_s2);
      default:       src_tick = 1'b0;
    endcase
    // Only the unsynchronised external path keeps running in sleep
    awake = ~sleep_i |
            (q.ctrl.no_sync & (q.ctrl.clock_source_select == GST_SRC_EXT));
  end

  // Gate source, polarity and toggle selection
  always_comb begin
    case (q.gate.gate_source_select)
      GST_GATE_PIN:  gate_raw = q.gpin_s2;
      GST_GATE_CMP0: gate_raw = companion_8bit_timer_ovf_i;
      GST_GATE_CMP1: gate_raw = q.gate.comparator_sync ? q.c1_lat : comparator_one_out_i;
      GST_GATE_CMP2: gate_raw = q.gate.comparator_sync ? q.c2_lat : comparator_two_out_i;
      default:       gate_raw = 1'b0;
    endcase
    gate_lvl = q.gate.gate_polarity ? gate_raw : ~gate_raw;
    gate_val = q.gate.gate_toggle_mode ? q.toggle : gate_lvl;
    run      = q.ctrl.timer_on & (~q.gate.gate_enable | gate_val) & awake;
    pre_tick = run & src_tick;
    cnt_tick = pre_tick & prescale_hit(q.presc, q.ctrl.prescale_select);
    ovf_set  = cnt_tick & (q.count == `GST_COUNT_MAX);
  end

  // Next state
  always_comb begin
    next_q = q;
    // Input sampling; first stages feed only the second stages
    next_q.ext_s1   = ext_pin_sel;
    next_q.ext_s2   = q.ext_s1;
    next_q.ext_raw  = ext_pin_sel;
    next_q.ext_prev = ext_lvl;
    next_q.lf_s1    = low_freq_internal_osc_i;
    next_q.lf_s2    = q.lf_s1;
    next_q.lf_prev  = q.lf_s2;
    next_q.gpin_s1  = gate_pin_i;
    next_q.gpin_s2  = q.gpin_s1;
    next_q.idiv     = q.idiv + 2'h1;
    // Crystal amplifier runs whenever enabled, sleep or not
    next_q.xtal_out = q.ctrl.crystal_osc_enable & ~crystal_in_i;
    // Comparators latched on the counter clock when synchronised
    if (src_tick) begin
      next_q.c1_lat = comparator_one_out_i;
      next_q.c2_lat = comparator_two_out_i;
    end
    // Gate toggle flip-flop
    next_q.gate_prev = gate_lvl;
    if (!q.gate.gate_toggle_mode || !q.ctrl.timer_on) begin
      next_q.toggle = 1'b0;
    end else if (rise(q.gate_prev, gate_lvl)) begin
      next_q.toggle = ~q.toggle;
    end
    // Falling edge arms the counter
    if (!q.ctrl.timer_on) begin
      next_q.armed = 1'b0;
    end else if (fall(q.ext_prev, ext_lvl)) begin
      next_q.armed = 1'b1;
    end
    // Prescaler and counter
    if (!q.ctrl.timer_on) begin
      next_q.presc = 3'h0;
    end else if (pre_tick) begin
      next_q.presc = q.presc + 3'h1;
    end
    if (cnt_tick) begin
      next_q.count = q.count + 16'h0001;
    end
    // Register writes take precedence over a coincident increment
    if (wr_ctrl) begin
      next_q.ctrl = gst_ctrl_t'(apb_req_i.pwdata[7:0]);
      next_q.ctrl.unused = 1'b0;
    end
    if (wr_gate) begin
      next_q.gate = gst_gate_t'(apb_req_i.pwdata[7:0]);
      next_q.gate.unused = 2'h0;
    end
    if (wr_low) begin
      next_q.count[7:0] = apb_req_i.pwdata[7:0];
    end
    if (wr_high) begin
      next_q.count[15:8] = apb_req_i.pwdata[7:0];
    end
    if (wr_count) begin
      next_q.presc = 3'h0;
      next_q.armed = 1'b0;
    end
    // Overflow flag: write one clears, a new rollover wins
    if (wr_stat && apb_req_i.pwdata[`GST_STAT_OVF_BIT]) begin
      next_q.overflow_flag = 1'b0;
    end
    if (ovf_set) begin
      next_q.overflow_flag = 1'b1;
    end
    next_q.wake = ovf_set & sleep_i;
    if (setup_ph) begin
      next_q.prdata = rd_mux;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q               <= '0;
      q.ctrl          <= gst_ctrl_t'(`GST_CTRL_RST);
      q.gate          <= gst_gate_t'(`GST_GATE_RST);
      q.count         <= `GST_COUNT_RST;
    end else begin
      q <= next_q;
    end
  end

  // Outputs
  assign prdata_o        = q.prdata;
  assign pready_o        = 1'b1;
  assign pslverr_o       = access_ph & ~mapped;
  assign count_o         = q.count;
  assign overflow_flag_o = q.overflow_flag;
  assign wake_o          = q.wake;
  assign crystal_out_o   = q.xtal_out;

  // ==========================================================================
  // Assertions
  default clocking gst_cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  off_holds_count_a: assert property (
    !q.ctrl.timer_on && !wr_count |=> q.count == $past(q.count))
    else $error("count moved while timer off");

  gate_holds_count_a: assert property (
    q.ctrl.timer_on && q.gate.gate_enable && !gate_val && !wr_count
      |=> q.count == $past(q.count))
    else $error("count moved while gate inactive");

  sys_clock_rate_a: assert property (
    q.ctrl.clock_source_select == GST_SRC_SYS && q.ctrl.prescale_select == 2'h0 && run
      && !wr_count |=> q.count == $past(q.count) + 16'h0001)
    else $error("system clock source did not count every cycle");

  count_write_a: assert property (
    wr_low |=> q.count[7:0] == $past(apb_req_i.pwdata[7:0]) && q.presc == 3'h0 && !q.armed)
    else $error("low byte write did not take effect or clear prescaler");

  rollover_flag_a: assert property (
    ovf_set && !wr_count |=> q.overflow_flag && q.count == 16'h0000)
    else $error("rollover did not wrap and set overflow flag");

  arm_before_count_a: assert property (
    q.ctrl.clock_source_select == GST_SRC_EXT && !q.armed |-> !cnt_tick)
    else $error("external count without a prior falling edge");

  toggle_clear_a: assert property (
    !q.gate.gate_toggle_mode |=> !q.toggle)
    else $error("toggle flip-flop not held clear");

  prescale_eight_a: assert property (
    cnt_tick && q.ctrl.prescale_select == 2'h3 |-> q.presc == 3'h7)
    else $error("divide by eight counted early");

  instr_clock_a: assert property (
    cnt_tick && q.ctrl.clock_source_select == GST_SRC_INSTR |-> q.idiv == `GST_INSTR_LAST)
    else $error("instruction clock source counted off phase");

  low_polarity_a: assert property (
    q.gate.gate_enable && !q.gate.gate_toggle_mode && !q.gate.gate_polarity
      && q.gate.gate_source_select == GST_GATE_PIN && q.gpin_s2 |-> !cnt_tick)
    else $error("counted with active-low gate high");

  sleep_stop_a: assert property (
    sleep_i && !(q.ctrl.no_sync && q.ctrl.clock_source_select == GST_SRC_EXT) |-> !cnt_tick)
    else $error("counted in sleep without asynchronous external source");

  pin_sync_a: assert property (
    $past(rst_b_i, 2) |-> q.ext_s2 == $past(ext_pin_sel, 2))
    else $error("external input not delayed by two stages");

  off_clears_gate_a: assert property (
    !q.ctrl.timer_on |=> !q.toggle && !q.armed)
    else $error("timer off did not clear gate flip-flop");

  high_write_a: assert property (
    wr_high |=> q.count[15:8] == $past(apb_req_i.pwdata[7:0]) && q.presc == 3'h0)
    else $error("high byte write did not take effect");

  flag_sticky_a: assert property (
    q.overflow_flag && !wr_stat |=> q.overflow_flag)
    else $error("overflow flag cleared without software");

  sleep_wake_a: assert property (
    ovf_set && sleep_i |=> wake_o)
    else $error("rollover in sleep gave no wake pulse");

  companion_gate_a: assert property (
    q.gate.gate_enable && !q.gate.gate_toggle_mode && q.gate.gate_polarity
      && q.gate.gate_source_select == GST_GATE_CMP0 && !companion_8bit_timer_ovf_i
      |-> !cnt_tick)
    else $error("counted with companion gate closed");

  toggle_flip_a: assert property (
    q.gate.gate_toggle_mode && q.ctrl.timer_on && rise(q.gate_prev, gate_lvl)
      |=> q.toggle != $past(q.toggle))
    else $error("toggle flip-flop missed an edge");

  crystal_drive_a: assert property (
    q.ctrl.crystal_osc_enable |=> crystal_out_o == !$past(crystal_in_i))
    else $error("crystal amplifier not driving");

  read_path_a: assert property (
    setup_ph |=> prdata_o == $past(rd_mux))
    else $error("read data not captured in setup phase");

  cmp_latch_a: assert property (
    src_tick |=> q.c1_lat == $past(comparator_one_out_i)
      && q.c2_lat == $past(comparator_two_out_i))
    else $error("comparator not latched on counter clock");

  ext_edge_count_a: assert property (
    q.ctrl.clock_source_select == GST_SRC_EXT && run && q.armed && !wr_count
      && q.ctrl.prescale_select == 2'h0 && rise(q.ext_prev, ext_lvl)
      |=> q.count == $past(q.count) + 16'h0001)
    else $error("external rising edge not counted");

  rollover_c: cover property (ovf_set ##1 q.overflow_flag);
  toggle_flip_c: cover property (q.gate.gate_toggle_mode && !q.toggle ##1 q.toggle);
  ext_count_c: cover property (q.ctrl.clock_source_select == GST_SRC_EXT && cnt_tick);
  sleep_count_c: cover property (sleep_i && cnt_tick);
  companion_gate_c: cover property (q.gate.gate_source_select == GST_GATE_CMP0 && cnt_tick);

endmodule

//--- hw/gst_defs.svh
// Register offsets, field positions, reset values and timing counts of the gated timer
`ifndef GST_DEFS_SVH
`define GST_DEFS_SVH

// ==========================================================================
// Register byte offsets on the APB bus
`define GST_OFF_CTRL      12'h000
`define GST_OFF_GATE      12'h004
`define GST_OFF_CNT_LOW   12'h008
`define GST_OFF_CNT_HIGH  12'h00C
`define GST_OFF_STATUS    12'h010

// ==========================================================================
// Field positions
`define GST_STAT_OVF_BIT   0
`define GST_STAT_ARMED_BIT 1

// ==========================================================================
// Reset values and the counter maximum
`define GST_CTRL_RST  8'h00
`define GST_GATE_RST  8'h00
`define GST_COUNT_RST 16'h0000
`define GST_COUNT_MAX 16'hFFFF

// ==========================================================================
// Timing counts: instruction clock is the system clock divided by four
`define GST_INSTR_DIV      4
`define GST_INSTR_LAST     2'h3

`endif

//--- hw/gst_pkg.sv
// Types shared by the gated timer design
package gst_pkg;

  // ==========================================================================
  // Clock and gate source encodings
  typedef enum logic [1:0] {
    GST_SRC_INSTR = 2'h0,
    GST_SRC_SYS   = 2'h1,
    GST_SRC_EXT   = 2'h2,
    GST_SRC_LFOSC = 2'h3
  } gst_clk_src_t;

  typedef enum logic [1:0] {
    GST_GATE_PIN  = 2'h0,
    GST_GATE_CMP0 = 2'h1,
    GST_GATE_CMP1 = 2'h2,
    GST_GATE_CMP2 = 2'h3
  } gst_gate_src_t;

  // ==========================================================================
  // Control register layouts
  typedef struct packed {
    gst_clk_src_t clock_source_select;
    logic [1:0]   prescale_select;
    logic         crystal_osc_enable;
    logic         no_sync;
    logic         unused;
    logic         timer_on;
  } gst_ctrl_t;

  typedef struct packed {
    logic          gate_enable;
    logic          gate_polarity;
    logic          gate_toggle_mode;
    logic [1:0]    unused;
    logic          comparator_sync;
    gst_gate_src_t gate_source_select;
  } gst_gate_t;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } gst_apb_req_t;

  // ==========================================================================
  // Whole state of the timer
  typedef struct packed {
    gst_ctrl_t   ctrl;
    gst_gate_t   gate;
    logic [15:0] count;
    logic [2:0]  presc;
    logic [1:0]  idiv;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_raw;
    logic        ext_prev;
    logic        lf_s1;
    logic        lf_s2;
    logic        lf_prev;
    logic        gpin_s1;
    logic        gpin_s2;
    logic        c1_lat;
    logic        c2_lat;
    logic        gate_prev;
    logic        toggle;
    logic        armed;
    logic        overflow_flag;
    logic        wake;
    logic        xtal_out;
    logic [31:0] prdata;
  } gst_state_t;

endpackage

//--- tb/gst_far_model.sv
// Far-side model: external clock pin, crystal, low-frequency oscillator, companion timer
`timescale 1ns/1ps

module gst_far_model (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic ext_run_i,
  input  wire logic ext_level_i,
  output logic      ext_clk_o,
  output logic      crystal_o,
  output logic      lf_osc_o,
  output logic      companion_ovf_o
);
  // ==========================================================================
  // Free-running divider that paces every far-side source
  logic [7:0] div_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Pin period 8 cycles when running, bench level when stopped
  assign ext_clk_o       = ext_run_i ? div_q[2] : ext_level_i;
  assign crystal_o       = div_q[3];
  assign lf_osc_o        = div_q[2];
  assign companion_ovf_o = (div_q == 8'hFF);
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the gated sixteen-bit timer
`timescale 1ns/1ps
`include "gst_defs.svh"

module tb_top
  import gst_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] gate;
    logic [2:0] pins;
    logic [7:0] delta;
  } gst_tb_row_t;

  logic         clk_i = 1'b0;
  logic         rst_b_i = 1'b0;
  gst_apb_req_t req = '0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         ext_run = 1'b1;
  logic         ext_level = 1'b0;
  logic         gate_pin = 1'b0;
  logic         cmp_one = 1'b0;
  logic         cmp_two = 1'b0;
  logic         sleep = 1'b0;
  logic         ext_clk;
  logic         crystal;
  logic         lf_osc;
  logic         comp_ovf;
  logic [15:0]  count;
  logic         ovf;
  logic         wake;
  logic         xtal;
  logic         crystal_d;
  int           num_errors = 0;
  int           check_count = 0;
  int           cycles = 0;
  // Rows: control, gate, {pin, cmp one, cmp two}, counts in 64 cycles
  gst_tb_row_t  rows [20] = '{
    '{8'h41, 8'h00, 3'h0, 8'h40}, '{8'h51, 8'h00, 3'h0, 8'h20}, '{8'h61, 8'h00, 3'h0, 8'h10},
    '{8'h71, 8'h00, 3'h0, 8'h08}, '{8'h01, 8'h00, 3'h0, 8'h10}, '{8'h31, 8'h00, 3'h0, 8'h02},
    '{8'hC1, 8'h00, 3'h0, 8'h08}, '{8'h81, 8'h00, 3'h0, 8'h08}, '{8'h85, 8'h00, 3'h0, 8'h08},
    '{8'h89, 8'h00, 3'h0, 8'h04}, '{8'h40, 8'h00, 3'h0, 8'h00}, '{8'h41, 8'h40, 3'h0, 8'h40},
    '{8'h41, 8'h80, 3'h4, 8'h00}, '{8'h41, 8'h80, 3'h0, 8'h40}, '{8'h41, 8'hC0, 3'h4, 8'h40},
    '{8'h41, 8'hC0, 3'h0, 8'h00}, '{8'h41, 8'hC2, 3'h2, 8'h40}, '{8'h41, 8'hC3, 3'h2, 8'h00},
    '{8'h41, 8'hC6, 3'h2, 8'h40}, '{8'h41, 8'hC7, 3'h1, 8'h40}};

  // ==========================================================================
  // Clock, design and far-side model
  always #5 clk_i = ~clk_i;

  gst_timer gst_timer_inst (
    .clk_i                      (clk_i),
    .rst_b_i                    (rst_b_i),
    .apb_req_i                  (req),
    .prdata_o                   (prdata),
    .pready_o                   (pready),
    .pslverr_o                  (pslverr),
    .external_clock_pin_i       (ext_clk),
    .crystal_in_i               (crystal),
    .crystal_out_o              (xtal),
    .low_freq_internal_osc_i    (lf_osc),
    .gate_pin_i                 (gate_pin),
    .companion_8bit_timer_ovf_i (comp_ovf),
    .comparator_one_out_i       (cmp_one),
    .comparator_two_out_i       (cmp_two),
    .sleep_i                    (sleep),
    .count_o                    (count),
    .overflow_flag_o            (ovf),
    .wake_o                     (wake)
  );

  gst_far_model gst_far_model_inst (
    .clk_i           (clk_i),
    .rst_b_i         (rst_b_i),
    .ext_run_i       (ext_run),
    .ext_level_i     (ext_level),
    .ext_clk_o       (ext_clk),
    .crystal_o       (crystal),
    .lf_osc_o        (lf_osc),
    .companion_ovf_o (comp_ovf)
  );

  // ==========================================================================
  // Verdict, comparisons and bus tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Setup, access held until pready, then one idle edge before the next request
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    req <= '{1'b1, 1'b0, wr, a, {24'h000000, d}};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req <= '0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk_word("read data", exp, r);
    chk_flag("slave error", (a > `GST_OFF_STATUS), e);
  endtask

  // Counts gained over a fixed number of cycles
  task automatic run_delta(input string what, input int cyc, input logic [7:0] exp);
    logic [15:0] a;
    a = count;
    repeat (cyc) @(posedge clk_i);
    chk_word(what, {24'h000000, exp}, {16'h0000, count - a});
  endtask

  // Crystal level one cycle back, to match the registered amplifier
  always @(posedge clk_i) crystal_d <= crystal;

  // Hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      num_errors++;
      test_done();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    int n;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    foreach (rows[i]) begin
      {gate_pin, cmp_one, cmp_two} <= rows[i].pins;
      wr(`GST_OFF_CTRL, 8'h00);
      wr(`GST_OFF_CNT_LOW, 8'h00);
      wr(`GST_OFF_GATE, rows[i].gate);
      wr(`GST_OFF_CTRL, rows[i].ctrl);
      repeat (12) @(posedge clk_i);
      run_delta("count step", 64, rows[i].delta);
      $display("row %0d done", i);
    end
    // Second reset while counting, then reset values and unmapped place
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    chk_word("count after reset", 32'h0, {16'h0000, count});
    for (logic [11:0] a = 12'h000; a <= 12'h014; a += 12'h004) rd_chk(a, 32'h0);
    wr(`GST_OFF_GATE, 8'hDF);
    rd_chk(`GST_OFF_GATE, 32'h000000C7);
    wr(`GST_OFF_CTRL, 8'hFE);
    rd_chk(`GST_OFF_CTRL, 32'h000000FC);
    chk_flag("crystal drive", ~crystal_d, xtal);
    repeat (8) @(posedge clk_i);
    chk_flag("crystal drive", ~crystal_d, xtal);
    wr(`GST_OFF_CTRL, 8'h00);
    wr(`GST_OFF_GATE, 8'h00);
    wr(`GST_OFF_CNT_LOW, 8'h5A);
    wr(`GST_OFF_CNT_HIGH, 8'hA5);
    rd_chk(`GST_OFF_CNT_LOW, 32'h0000005A);
    rd_chk(`GST_OFF_CNT_HIGH, 32'h000000A5);
    $display("registers done");
    // Byte write while running replaces the byte and restarts the prescaler
    wr(`GST_OFF_CTRL, 8'h71);
    repeat (5) @(posedge clk_i);
    wr(`GST_OFF_CNT_LOW, 8'h10);
    repeat (4) @(posedge clk_i);
    chk_word("low byte kept", 32'h00000010, {24'h000000, count[7:0]});
    repeat (6) @(posedge clk_i);
    chk_word("low byte step", 32'h00000011, {24'h000000, count[7:0]});
    $display("prescaler done");
    // Start-up wait: preset FC00h, the flag rises 1024 ticks later and stays
    wr(`GST_OFF_CTRL, 8'h00);
    wr(`GST_OFF_STATUS, 8'h01);
    wr(`GST_OFF_CNT_HIGH, 8'hFC);
    wr(`GST_OFF_CNT_LOW, 8'h00);
    wr(`GST_OFF_CTRL, 8'h41);
    repeat (1000) @(posedge clk_i);
    chk_flag("flag early", 1'b0, ovf);
    repeat (30) @(posedge clk_i);
    chk_flag("overflow flag", 1'b1, ovf);
    wr(`GST_OFF_CTRL, 8'h00);
    rd_chk(`GST_OFF_STATUS, 32'h00000001);
    wr(`GST_OFF_STATUS, 8'h01);
    rd_chk(`GST_OFF_STATUS, 32'h00000000);
    $display("overflow done");
    // Asleep: unsynchronised external counting wakes on rollover, system clock stops
    sleep <= 1'b1;
    wr(`GST_OFF_CNT_HIGH, 8'hFF);
    wr(`GST_OFF_CNT_LOW, 8'hFE);
    wr(`GST_OFF_CTRL, 8'h85);
    n = 0;
    while (wake !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk_flag("wake pulse", 1'b1, wake);
    wr(`GST_OFF_CTRL, 8'h41);
    run_delta("asleep system clock", 32, 8'h00);
    sleep <= 1'b0;
    $display("sleep done");
    // First rising edge after enabling with the pin low is not counted
    ext_run <= 1'b0;
    wr(`GST_OFF_CTRL, 8'h00);
    wr(`GST_OFF_CNT_LOW, 8'h00);
    wr(`GST_OFF_CNT_HIGH, 8'h00);
    wr(`GST_OFF_CTRL, 8'h81);
    repeat (8) @(posedge clk_i);
    ext_level <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk_word("unarmed edge", 32'h0, {16'h0000, count});
    ext_level <= 1'b0;
    repeat (8) @(posedge clk_i);
    ext_level <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk_word("armed edge", 32'h1, {16'h0000, count});
    $display("arming done");
    // Toggle gate: a pin pulse opens it; stop and toggle-mode clear both close it
    wr(`GST_OFF_CTRL, 8'h00);
    wr(`GST_OFF_GATE, 8'hC0);
    wr(`GST_OFF_GATE, 8'hE0);
    wr(`GST_OFF_CTRL, 8'h41);
    run_delta("toggle idle", 16, 8'h00);
    gate_pin <= 1'b1;
    repeat (4) @(posedge clk_i);
    gate_pin <= 1'b0;
    repeat (8) @(posedge clk_i);
    run_delta("toggle open", 16, 8'h10);
    wr(`GST_OFF_CTRL, 8'h00);
    wr(`GST_OFF_CTRL, 8'h41);
    run_delta("toggle after stop", 16, 8'h00);
    gate_pin <= 1'b1;
    repeat (4) @(posedge clk_i);
    gate_pin <= 1'b0;
    wr(`GST_OFF_GATE, 8'hC0);
    wr(`GST_OFF_GATE, 8'hE0);
    run_delta("toggle after mode clear", 16, 8'h00);
    $display("toggle done");
    // Companion wrap pulse opens an active-high gate once per 256 cycles
    wr(`GST_OFF_CTRL, 8'h00);
    wr(`GST_OFF_GATE, 8'hC1);
    wr(`GST_OFF_CTRL, 8'h41);
    run_delta("companion gate", 256, 8'h01);
    $display("companion done");
    test_done();
  end
endmodule
